// [verilog/vit_params.svh]
// constants for the vectored interrupt controller and interval timer
// assumes a wishbone word-addressed register map on byte offsets
`ifndef VIT_PARAMS_SVH
`define VIT_PARAMS_SVH
`define STACK_DEPTH 7
`define NUM_SRC 6
// register byte offsets
`define OFF_MASK 8'h00
`define OFF_CTRL 8'h04
`define OFF_FORCE_CLEAR 8'h08
`define OFF_PENDING 8'h0C
`define OFF_ARITH 8'h10
`define OFF_MODE 8'h14
`define OFF_TIMER_COUNT 8'h18
`define OFF_TIMER_PRESCALE 8'h1C
`define OFF_TIMER_PERIOD 8'h20
`define OFF_DEPTH 8'h24
// control register fields
`define CTRL_EDGE_LO 0
`define CTRL_ALT_BIT 3
`define CTRL_NEST_BIT 4
`define CTRL_TIMER_BIT 5
// force/clear fields
`define FC_FORCE_LO 0
`define FC_CLEAR_LO 8
// source indices, lower index wins
`define SRC_EXT2 3'h0
`define SRC_SP0TX 3'h1
`define SRC_SP0RX 3'h2
`define SRC_SP1TX 3'h3
`define SRC_SP1RX 3'h4
`define SRC_TIMER 3'h5
// vectors
`define VEC_RESET 14'h0000
`define VEC_BASE 14'h0004
`define VEC_STRIDE 14'h0004
`define VEC_LOWEST 14'h0018
// reset values
`define RST_MASK 6'h00
`define RST_MODE 16'h0000
`define RST_ZERO16 16'h0000
`define RST_ZERO8 8'h00
`endif

// [verilog/vit_pkg.sv]
// types shared by the interrupt controller
// assumes vit_params.svh is on the include path
`include "vit_params.svh"
package vit_pkg;
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;

  typedef struct packed {
    logic [15:0] arith;
    logic [15:0] mode;
    logic [`NUM_SRC-1:0] mask;
    logic [2:0] idx;
  } stack_entry_t;

  typedef struct packed {
    bus_state_t bus;
    logic [31:0] rdata;
    logic [`NUM_SRC-1:0] mask;
    logic [`NUM_SRC-1:0] pend;
    logic [5:0] ctrl;
    logic [2:0] extPrev;
    logic [15:0] arith;
    logic [15:0] mode;
    logic [15:0] timer_count;
    logic [15:0] timer_period;
    logic [7:0] timer_prescale;
    logic [7:0] scaleCnt;
    logic [2:0] depth;
    stack_entry_t [`STACK_DEPTH-1:0] stack;
    logic intReq;
    logic [2:0] selIdx;
    logic [13:0] vector;
    logic pcLoad;
    logic timerFire;
  } state_t;
endpackage

// [verilog/vectored_interrupt_timer.sv]
// vectored prioritized interrupt controller with interval timer
// assumes one clock, sync reset, sequencer handshake via svcAck/rtiExec
//
// Function
// - fixed vectors, ext two highest, timer lowest
// - vector slots are four addresses apart
// - requests ANDed with mask before selection
// - highest priority unmasked request is selected
// - fixed priority, maskable; reset never masked
// - each external input edge or level
// - control bit 4 selects nested or sequential
// - write-only force and clear per interrupt
// - acknowledge pushes status, loads vector address
// - status stack holds seven entries
// - return from interrupt pops and restores status
// - ext one/zero only in serial-one alternate mode
// - timer and serial ports raise internal requests
// - each serial direction interrupts per word
// - autobuffer interrupts after whole buffer
// - count decrements every prescale plus one cycles
// - zero count interrupts and reloads period
// - reset empties stack, masks all, clears mode
`include "vit_params.svh"
module vectored_interrupt_timer
  import vit_pkg::*;
#(
  parameter int STACK_DEPTH = `STACK_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // external request pins, active low
  input wire logic extReqTwoN,
  input wire logic extReqOneN,
  input wire logic extReqZeroN,
  // serial port events: per-word done, buffer end, autobuffer mode
  input wire logic [3:0] serialWordDone,
  input wire logic [3:0] serialBufferDone,
  input wire logic [3:0] serialAutobuf,
  // program sequencer
  input wire logic svcAck,
  input wire logic rtiExec,
  output logic intReq,
  output logic [13:0] vectorAddr,
  output logic pcLoad,
  output logic [15:0] arithStatus,
  output logic [15:0] modeStatus
);

  state_t st, next_st;

  function automatic logic [13:0] vecOf(input logic [2:0] idx);
    vecOf = `VEC_BASE + `VEC_STRIDE * {11'h000, idx};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = sel[b] ? d[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // request sources

  logic [2:0] extNow, extEdge, extReq;
  logic [3:0] serialEv;
  logic [`NUM_SRC-1:0] srcEvent, levelReq, maskedReq, eligible;
  logic altMode, take, pop, timerTick;
  logic found;
  logic [2:0] foundIdx;
  logic [31:0] wr, rd;
  stack_entry_t topEntry;

  always_comb begin
    extNow = {~extReqTwoN, ~extReqOneN, ~extReqZeroN};
    extEdge = extNow & ~st.extPrev;
    // latched edge events or raw levels, per control bit
    for (int i = 0; i < 3; i++) begin
      extReq[i] = st.ctrl[`CTRL_EDGE_LO + i] ? extEdge[i] : extNow[i];
    end
    altMode = st.ctrl[`CTRL_ALT_BIT];
    for (int i = 0; i < 4; i++) begin
      serialEv[i] = serialAutobuf[i] ? serialBufferDone[i] : serialWordDone[i];
    end
    srcEvent = '0;
    levelReq = '0;
    // edge-mode externals and internal sources latch; level-mode externals feed straight in
    srcEvent[`SRC_EXT2] = st.ctrl[`CTRL_EDGE_LO + 2] & extReq[2];
    levelReq[`SRC_EXT2] = ~st.ctrl[`CTRL_EDGE_LO + 2] & extReq[2];
    srcEvent[`SRC_SP0TX] = serialEv[0];
    srcEvent[`SRC_SP0RX] = serialEv[1];
    if (altMode) begin
      srcEvent[`SRC_SP1TX] = st.ctrl[`CTRL_EDGE_LO + 1] & extReq[1];
      levelReq[`SRC_SP1TX] = ~st.ctrl[`CTRL_EDGE_LO + 1] & extReq[1];
      srcEvent[`SRC_SP1RX] = st.ctrl[`CTRL_EDGE_LO] & extReq[0];
      levelReq[`SRC_SP1RX] = ~st.ctrl[`CTRL_EDGE_LO] & extReq[0];
    end else begin
      srcEvent[`SRC_SP1TX] = serialEv[2];
      srcEvent[`SRC_SP1RX] = serialEv[3];
    end
    srcEvent[`SRC_TIMER] = st.timerFire;
  end

  ////////////////////////////////////////////////////////////////////////////
  // selection

  always_comb begin
    topEntry = st.stack[st.depth - 3'd1];
    maskedReq = (st.pend | levelReq) & st.mask;
    eligible = '0;
    for (int i = 0; i < `NUM_SRC; i++) begin
      if (st.depth == 3'(STACK_DEPTH)) begin
        eligible[i] = 1'b0;
      end else if (st.depth == 3'd0) begin
        eligible[i] = maskedReq[i];
      end else if (st.ctrl[`CTRL_NEST_BIT]) begin
        eligible[i] = maskedReq[i] && (3'(i) < topEntry.idx);
      end else begin
        eligible[i] = 1'b0;
      end
    end
    found = 1'b0;
    foundIdx = 3'h0;
    for (int i = `NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        found = 1'b1;
        foundIdx = 3'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    wr = merge(32'h0000_0000, dat_i, sel_i);
    rd = 32'h0000_0000;
    pop = rtiExec && (st.depth != 3'd0);
    take = svcAck && st.intReq && !rtiExec;
    next_st.extPrev = extNow;
    next_st.pcLoad = 1'b0;
    next_st.timerFire = 1'b0;

    // timer: one tick every prescale+1 cycles
    timerTick = 1'b0;
    if (st.ctrl[`CTRL_TIMER_BIT]) begin
      if (st.scaleCnt == `RST_ZERO8) begin
        next_st.scaleCnt = st.timer_prescale;
        timerTick = 1'b1;
      end else begin
        next_st.scaleCnt = st.scaleCnt - 8'h01;
      end
    end
    if (timerTick) begin
      if (st.timer_count == `RST_ZERO16) begin
        next_st.timer_count = st.timer_period;
        next_st.timerFire = 1'b1;
      end else begin
        next_st.timer_count = st.timer_count - 16'h0001;
      end
    end

    // bus access, one cycle after the strobe
    if (st.bus == BUS_ACK) begin
      next_st.bus = BUS_IDLE;
    end else if (cyc_i && stb_i) begin
      next_st.bus = BUS_ACK;
      if (adr_i == `OFF_MASK) begin
        rd = {26'h0, st.mask};
        if (we_i) next_st.mask = 6'(merge({26'h0, st.mask}, dat_i, sel_i));
      end else if (adr_i == `OFF_CTRL) begin
        rd = {26'h0, st.ctrl};
        if (we_i) next_st.ctrl = 6'(merge({26'h0, st.ctrl}, dat_i, sel_i));
      end else if (adr_i == `OFF_FORCE_CLEAR) begin
        // write-only; reads return zero
        if (we_i) begin
          next_st.pend = next_st.pend & ~wr[`FC_CLEAR_LO +: `NUM_SRC];
          next_st.pend = next_st.pend | wr[`FC_FORCE_LO +: `NUM_SRC];
        end
      end else if (adr_i == `OFF_PENDING) begin
        rd = {26'h0, st.pend | levelReq};
      end else if (adr_i == `OFF_ARITH) begin
        rd = {16'h0, st.arith};
        if (we_i) next_st.arith = 16'(merge({16'h0, st.arith}, dat_i, sel_i));
      end else if (adr_i == `OFF_MODE) begin
        rd = {16'h0, st.mode};
        if (we_i) next_st.mode = 16'(merge({16'h0, st.mode}, dat_i, sel_i));
      end else if (adr_i == `OFF_TIMER_COUNT) begin
        rd = {16'h0, st.timer_count};
        if (we_i) next_st.timer_count = 16'(merge({16'h0, st.timer_count}, dat_i, sel_i));
      end else if (adr_i == `OFF_TIMER_PRESCALE) begin
        rd = {24'h0, st.timer_prescale};
        if (we_i) next_st.timer_prescale = 8'(merge({24'h0, st.timer_prescale}, dat_i, sel_i));
      end else if (adr_i == `OFF_TIMER_PERIOD) begin
        rd = {16'h0, st.timer_period};
        if (we_i) next_st.timer_period = 16'(merge({16'h0, st.timer_period}, dat_i, sel_i));
      end else if (adr_i == `OFF_DEPTH) begin
        rd = {29'h0, st.depth};
      end
      next_st.rdata = rd;
    end

    // acknowledge clears the taken latch before new events set it again
    if (take) begin
      next_st.stack[st.depth] = '{arith: st.arith, mode: st.mode, mask: st.mask,
                                  idx: st.selIdx};
      next_st.depth = st.depth + 3'd1;
      next_st.pend[st.selIdx] = 1'b0;
      next_st.pcLoad = 1'b1;
    end
    if (pop) begin
      next_st.arith = topEntry.arith;
      next_st.mode = topEntry.mode;
      next_st.mask = topEntry.mask;
      next_st.depth = st.depth - 3'd1;
    end
    // set wins over any clear in the same cycle
    next_st.pend = next_st.pend | srcEvent;

    next_st.intReq = found && !take && !pop;
    if (found) begin
      next_st.selIdx = foundIdx;
      next_st.vector = vecOf(foundIdx);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.mask <= `RST_MASK;
      st.mode <= `RST_MODE;
      st.vector <= `VEC_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign dat_o = st.rdata;
  assign ack_o = (st.bus == BUS_ACK);
  assign intReq = st.intReq;
  assign vectorAddr = st.vector;
  assign pcLoad = st.pcLoad;
  assign arithStatus = st.arith;
  assign modeStatus = st.mode;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_vector_top: assert property (st.intReq && st.selIdx == `SRC_EXT2 |->
    st.vector == `VEC_BASE) else $error("top priority vector wrong");
  chk_vector_stride: assert property (st.intReq |->
    st.vector == `VEC_BASE + `VEC_STRIDE * {11'h000, st.selIdx})
    else $error("vector not on four-word slot");
  chk_mask_gate: assert property (st.intReq |->
    ($past(maskedReq) & (6'h01 << st.selIdx)) != 6'h00)
    else $error("masked request selected");
  chk_priority_pick: assert property (st.intReq |->
    ($past(eligible) & ((6'h01 << st.selIdx) - 6'h01)) == 6'h00)
    else $error("lower priority request won");
  chk_seq_mode: assert property (!st.ctrl[`CTRL_NEST_BIT] && st.depth != 3'd0
    && !pop |=> !st.intReq) else $error("sequential mode preempted");
  chk_push_load: assert property (take |=> st.pcLoad &&
    st.depth == $past(st.depth) + 3'd1 && !st.intReq) else $error("acknowledge not pushed");
  chk_stack_full: assert property (st.depth == 3'(STACK_DEPTH) |=> !st.intReq)
    else $error("request beyond stack depth");
  chk_pop_restore: assert property (pop |=> st.mask == $past(topEntry.mask)
    && st.arith == $past(topEntry.arith)) else $error("status not restored");
  chk_timer_reload: assert property (timerTick && st.timer_count == 16'h0000 |=>
    st.timer_count == $past(st.timer_period) && st.timerFire ##1 st.pend[`SRC_TIMER])
    else $error("timer reload missing");
  chk_edge_latch: assert property (srcEvent[`SRC_EXT2] |=> st.pend[`SRC_EXT2])
    else $error("edge request lost");
  chk_reset_state: assert property (disable iff (1'b0) rst |=> st.depth == 3'd0
    && st.mask == 6'h00 && st.mode == 16'h0000) else $error("reset state wrong");

  cov_nested_take: cover property (take && st.depth == 3'd1);
  cov_timer_event: cover property (st.timerFire);
  cov_return: cover property (pop ##1 st.intReq);

endmodule // vectored_interrupt_timer

// [bench/seq_model.sv]
// sequencer stand-in: takes offered interrupts and issues returns
// assumes the registered intReq/vectorAddr offer and svcAck/rtiExec pulses
module seq_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // controller side
  input wire logic intReq,
  input wire logic [13:0] vectorAddr,
  input wire logic pcLoad,
  output logic svcAck,
  output logic rtiExec,
  // bench control
  input wire logic slow,
  input wire logic retReq,
  input wire logic autoRet,
  output logic [13:0] lastVec,
  output int takes
);
  timeunit 1ns;
  timeprecision 1ps;
  int waitCnt;
  always_ff @(posedge clk) begin
    if (rst) begin
      svcAck <= 1'b0;
      rtiExec <= 1'b0;
      waitCnt <= 0;
      takes <= 0;
      lastVec <= 14'h0000;
    end else begin
      waitCnt <= intReq ? waitCnt + 1 : 0;
      // slow mode lets the offer stand a few cycles before the take
      svcAck <= intReq && !svcAck && waitCnt >= (slow ? 3 : 0);
      rtiExec <= retReq | (autoRet & pcLoad);
      if (svcAck && intReq && !rtiExec) begin
        lastVec <= vectorAddr;
        takes <= takes + 1;
      end
    end
  end
endmodule // seq_model

// [bench/vectored_interrupt_timer_tb.sv]
// self-checking bench for the interrupt controller and interval timer
// assumes seq_model as sequencer and a bench-driven classic wishbone master
module vectored_interrupt_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, cyc, stb, we, ack, two, one, zero;
  logic svcAck, rtiExec, intReq, pcLoad, slow, retReq, autoRet;
  logic [7:0] adr, s;
  logic [31:0] dat, datO;
  logic [3:0] wordDone, bufDone, autobuf, v;
  logic [13:0] vecA, lastVec;
  logic [15:0] arith, mode, a;
  logic [5:0] m;
  int takes, n, seed = 57, checked = 0, miscompares = 0;
  vectored_interrupt_timer DUT (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(datO), .ack_o(ack), .extReqTwoN(two),
    .extReqOneN(one), .extReqZeroN(zero), .serialWordDone(wordDone),
    .serialBufferDone(bufDone), .serialAutobuf(autobuf), .svcAck(svcAck), .rtiExec(rtiExec),
    .intReq(intReq), .vectorAddr(vecA), .pcLoad(pcLoad), .arithStatus(arith),
    .modeStatus(mode));
  seq_model seq (.clk(clk), .rst(rst), .intReq(intReq), .vectorAddr(vecA), .pcLoad(pcLoad),
    .svcAck(svcAck), .rtiExec(rtiExec), .slow(slow), .retReq(retReq), .autoRet(autoRet),
    .lastVec(lastVec), .takes(takes));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                    output logic [31:0] q);
    int k = 0;
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, ad, d};
    do @(posedge clk); while (ack !== 1'b1 && ++k < 20);
    q = datO;
    {cyc, stb, we} <= 3'b000;
    if (k >= 20) miscompares++;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, ad, d, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] ad, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, ad, 32'h0, q);
    chk(nm, q, e);
  endtask
  task automatic evt(input logic [3:0] w, input logic [3:0] b, input logic [2:0] p);
    @(posedge clk);
    {wordDone, bufDone, two, one, zero} <= {w, b, ~p};
    @(posedge clk);
    {wordDone, bufDone, two, one, zero} <= {8'h00, 3'h7};
  endtask
  // a missing take shows as a cleared top bit, never as a stale vector match
  task automatic take(input logic [13:0] e);
    int t0 = takes;
    int k = 0;
    while (takes == t0 && k++ < 60) @(posedge clk);
    chk("vector", {17'h0, takes != t0, lastVec}, {17'h0, 1'b1, e});
  endtask
  task automatic none();
    int t0 = takes;
    repeat (12) @(posedge clk);
    chk("no take", 32'(takes - t0), 32'h0);
  endtask
  task automatic rti();
    @(posedge clk);
    retReq <= 1'b1;
    @(posedge clk);
    retReq <= 1'b0;
  endtask
  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #400000;
    miscompares++;
    summarize();
  end
  initial begin
    {cyc, stb, we, adr, dat, slow, retReq, autoRet} = '0;
    {wordDone, bufDone, autobuf, two, one, zero} = {12'h000, 3'h7};
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd("mask", 8'h00, 32'h0);
    rd("mode", 8'h14, 32'h0);
    rd("depth", 8'h24, 32'h0);
    chk("mode port", {16'h0, mode}, 32'h0);
    rd("unmapped", 8'h3C, 32'h0);
    wr(8'h08, 32'h3F);
    none();
    rd("force clear", 8'h08, 32'h0);
    rd("pending", 8'h0C, 32'h3F);
    wr(8'h08, 32'h3F00);
    rd("pending", 8'h0C, 32'h0);
    // random masks against random serial word events, lowest index first
    for (int k = 0; k < 6; k++) begin
      m = 6'($random(seed));
      v = 4'($random(seed));
      slow <= k[0];
      wr(8'h00, {26'h0, m});
      evt(v, 4'h0, 3'h0);
      for (int i = 0; i < 4; i++) if (v[i] && m[i + 1]) begin
        take(14'h0008 + 14'(4 * i));
        rti();
      end
      none();
      wr(8'h08, 32'h3F00);
    end
    wr(8'h00, 32'h3F);
    @(posedge clk) two <= 1'b0;
    take(14'h0004);
    @(posedge clk) two <= 1'b1;
    rti();
    wr(8'h04, 32'h4);
    evt(4'h0, 4'h0, 3'h4);
    take(14'h0004);
    rti();
    wr(8'h04, 32'h2);
    evt(4'h0, 4'h0, 3'h2);
    none();
    wr(8'h04, 32'hA);
    evt(4'h0, 4'h0, 3'h2);
    take(14'h0010);
    rti();
    wr(8'h04, 32'h0);
    autobuf <= 4'h1;
    evt(4'h1, 4'h0, 3'h0);
    none();
    evt(4'h0, 4'h1, 3'h0);
    take(14'h0008);
    rti();
    // nested: timer preempted by ext two, status restored level by level
    a = 16'($random(seed));
    wr(8'h04, 32'h10);
    wr(8'h10, {16'h0, a});
    wr(8'h08, 32'h20);
    take(14'h0018);
    wr(8'h10, {16'h0, ~a});
    wr(8'h08, 32'h1);
    take(14'h0004);
    rd("depth", 8'h24, 32'h2);
    rti();
    rd("arith", 8'h10, {16'h0, ~a});
    rti();
    rd("arith", 8'h10, {16'h0, a});
    chk("arith port", {16'h0, arith}, {16'h0, a});
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h20);
    take(14'h0018);
    wr(8'h08, 32'h1);
    none();
    rti();
    take(14'h0004);
    rti();
    // timer alone, auto return, so takes follow the fire period
    s = 8'(3 + {$random(seed)} % 4);
    wr(8'h00, 32'h20);
    wr(8'h20, 32'h2);
    wr(8'h1C, {24'h0, s});
    wr(8'h18, 32'h0);
    autoRet <= 1'b1;
    slow <= 1'b0;
    wr(8'h04, 32'h20);
    for (int j = 0; j < 3; j++) begin
      n = 0;
      do begin @(posedge clk); n++; end while (pcLoad !== 1'b1 && n < 200);
      if (j > 0) chk("timer period", 32'(n), 32'(3 * (s + 1)));
    end
    summarize();
  end
endmodule // vectored_interrupt_timer_tb
